// [design/hscr_map.svh]
`ifndef HSCR_MAP_SVH
`define HSCR_MAP_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define HSCR_CMD_MONITOR_LIMIT 8'hf2
`define HSCR_CMD_BUS_FAULT 8'hf3
`define HSCR_CMD_PIN_POLARITY 8'hf4

// ----------------------------------------
// reset values
// ----------------------------------------
`define HSCR_RST_MONITOR_LIMIT 16'h5572
`define HSCR_RST_BUS_FAULT 16'h00ef
`define HSCR_RST_PIN_POLARITY 16'h009b

// ----------------------------------------
// readable masks (read-only reserved bits return zero)
// ----------------------------------------
`define HSCR_RD_MASK_MONITOR_LIMIT 16'h7f7f
`define HSCR_RD_MASK_BUS_FAULT 16'h3fef
`define HSCR_RD_MASK_PIN_POLARITY 16'hfeff

// ----------------------------------------
// field positions
// ----------------------------------------
`define HSCR_CURRENT_LIMIT_CODE_HI 13
`define HSCR_CURRENT_LIMIT_CODE_LO 10
`define HSCR_VSCALE_BIT 1
`define HSCR_PWRSRC_BIT 0
`define HSCR_FAST_BIT 12
`define HSCR_FLTRST_BIT 7
`define HSCR_PGCLR_BIT 6
`define HSCR_MASSWR_BIT 5
`define HSCR_RTEMP_BIT 2
`define HSCR_DBON_BIT 1
`define HSCR_RBTPOL_BIT 9

`endif

// [design/hscr_pkg.sv]
package hscr_pkg;
    typedef enum logic [1:0] {
        HSCR_IDLE,
        HSCR_WRITE,
        HSCR_READ
    } hscr_acc_t;
endpackage

// [design/hscr_reg_word.sv]
`timescale 1ns/1ps
`include "hscr_map.svh"
module hscr_reg_word #(
    parameter logic [15:0] RST_VAL = 16'h0000,
    parameter logic [15:0] RD_MASK = 16'hffff
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    output logic [15:0] value_q,
    output logic [15:0] rd_value
);
    logic [15:0] value_d;

    always_comb begin
        value_d = value_q;
        if (wr_en) begin
            value_d = wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= RST_VAL;
        end else begin
            value_q <= value_d;
        end
    end

    assign rd_value = value_q & RD_MASK;
endmodule

// [design/hscr_top.sv]
`timescale 1ns/1ps
`include "hscr_map.svh"
module hscr_top #(
    parameter int DEBOUNCE_CYCLES = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_mass,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] fault_set,
    input wire logic enable_pin,
    input wire logic feedback_good,
    input wire logic gate_good,
    input wire logic drain_good,
    input wire logic fet_on,
    input wire logic [7:0] reboot_pin,
    input wire logic [7:0] gpio_sel_out,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic rsp_ack,
    output logic [3:0] current_limit_code,
    output logic voltage_scale_select,
    output logic power_voltage_source,
    output logic fast_bus_timing,
    output logic remote_sensor_select,
    output logic enable_active,
    output logic [15:0] fault_bits,
    output logic power_good_latch,
    output logic reboot_req,
    output logic [7:0] gpio_pull_low
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic hit_ml, hit_bf, hit_pp, wr_ok;
    logic [15:0] ml_q, bf_q, pp_q, ml_rd, bf_rd, pp_rd;
    hscr_pkg::hscr_acc_t acc;

    always_comb begin
        hit_ml = cmd_code == `HSCR_CMD_MONITOR_LIMIT;
        hit_bf = cmd_code == `HSCR_CMD_BUS_FAULT;
        hit_pp = cmd_code == `HSCR_CMD_PIN_POLARITY;
        wr_ok = cmd_valid && cmd_write && (!cmd_mass || bf_q[`HSCR_MASSWR_BIT]);
        if (!cmd_valid) begin
            acc = hscr_pkg::HSCR_IDLE;
        end else if (cmd_write) begin
            acc = hscr_pkg::HSCR_WRITE;
        end else begin
            acc = hscr_pkg::HSCR_READ;
        end
    end

    // whole-word write; reserved patterns are the host's duty, stored as written
    hscr_reg_word #(.RST_VAL(`HSCR_RST_MONITOR_LIMIT), .RD_MASK(`HSCR_RD_MASK_MONITOR_LIMIT))
        u_ml (.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr_ok && hit_ml),
              .wr_data(cmd_wdata), .value_q(ml_q), .rd_value(ml_rd));
    hscr_reg_word #(.RST_VAL(`HSCR_RST_BUS_FAULT), .RD_MASK(`HSCR_RD_MASK_BUS_FAULT))
        u_bf (.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr_ok && hit_bf),
              .wr_data(cmd_wdata), .value_q(bf_q), .rd_value(bf_rd));
    hscr_reg_word #(.RST_VAL(`HSCR_RST_PIN_POLARITY), .RD_MASK(`HSCR_RD_MASK_PIN_POLARITY))
        u_pp (.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr_ok && hit_pp),
              .wr_data(cmd_wdata), .value_q(pp_q), .rd_value(pp_rd));

    // ----------------------------------------
    // response
    // ----------------------------------------
    logic rsp_valid_d, rsp_ack_d;
    logic [15:0] rsp_rdata_d;
    always_comb begin
        rsp_valid_d = 1'b0;
        rsp_ack_d = 1'b0;
        rsp_rdata_d = 16'h0000;
        case (acc)
            hscr_pkg::HSCR_WRITE: begin
                rsp_valid_d = 1'b1;
                rsp_ack_d = wr_ok && (hit_ml || hit_bf || hit_pp);
            end
            hscr_pkg::HSCR_READ: begin
                rsp_valid_d = 1'b1;
                rsp_ack_d = hit_ml || hit_bf || hit_pp;
                if (hit_ml) begin
                    rsp_rdata_d = ml_rd;
                end else if (hit_bf) begin
                    rsp_rdata_d = bf_rd;
                end else if (hit_pp) begin
                    rsp_rdata_d = pp_rd;
                end
            end
            default: begin
                rsp_valid_d = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // pin synchronisers: three stages, change once stages 2 and 3 agree
    // ----------------------------------------
    logic [9:0] s1_q, s2_q, s3_q, pin_q, pin_d;
    always_comb begin
        pin_d = pin_q;
        for (int i = 0; i < 10; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                pin_d[i] = s3_q[i];
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 10'h000;
            s2_q <= 10'h000;
            s3_q <= 10'h000;
            pin_q <= 10'h000;
        end else begin
            s1_q <= {feedback_good, enable_pin, reboot_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
        end
    end

    // ----------------------------------------
    // enable debounce, fault clear, power-good, reboot edge
    // ----------------------------------------
    logic [15:0] db_cnt_q, db_cnt_d;
    logic en_q, en_d, pg_q, pg_d, rbt_q, rbt_d, rbt_prev_q;
    logic [15:0] flt_q, flt_d;
    logic [7:0] rbt_sel_pin;
    assign rbt_sel_pin = pin_q[7:0];

    always_comb begin
        db_cnt_d = db_cnt_q;
        en_d = en_q;
        if (!bf_q[`HSCR_DBON_BIT]) begin
            en_d = pin_q[8];
            db_cnt_d = 16'h0000;
        end else if (pin_q[8] == en_q) begin
            db_cnt_d = 16'h0000;
        end else if (db_cnt_q >= 16'(DEBOUNCE_CYCLES - 1)) begin
            en_d = pin_q[8];
            db_cnt_d = 16'h0000;
        end else begin
            db_cnt_d = db_cnt_q + 16'h0001;
        end
        flt_d = flt_q;
        if (en_d && !en_q && bf_q[`HSCR_FLTRST_BIT]) begin
            flt_d = 16'h0000;
        end
        flt_d = flt_d | fault_set; // new faults win over clear
        pg_d = pg_q;
        if (bf_q[`HSCR_PGCLR_BIT] ? !pin_q[9] : !fet_on) begin
            pg_d = 1'b0;
        end else if (pin_q[9] && gate_good && drain_good) begin
            pg_d = 1'b1;
        end
        rbt_d = pp_q[`HSCR_RBTPOL_BIT] ? (rbt_prev_q && !(|rbt_sel_pin))
                                       : (!rbt_prev_q && (|rbt_sel_pin));
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            db_cnt_q <= 16'h0000;
            en_q <= 1'b0;
            flt_q <= 16'h0000;
            pg_q <= 1'b0;
            rbt_q <= 1'b0;
            rbt_prev_q <= 1'b0;
        end else begin
            db_cnt_q <= db_cnt_d;
            en_q <= en_d;
            flt_q <= flt_d;
            pg_q <= pg_d;
            rbt_q <= rbt_d;
            rbt_prev_q <= |rbt_sel_pin;
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_ack <= 1'b0;
            rsp_rdata <= 16'h0000;
            current_limit_code <= 4'h0;
            voltage_scale_select <= 1'b0;
            power_voltage_source <= 1'b0;
            fast_bus_timing <= 1'b0;
            remote_sensor_select <= 1'b0;
            gpio_pull_low <= 8'h00;
        end else begin
            rsp_valid <= rsp_valid_d;
            rsp_ack <= rsp_ack_d;
            rsp_rdata <= rsp_rdata_d;
            current_limit_code <= ml_q[`HSCR_CURRENT_LIMIT_CODE_HI:`HSCR_CURRENT_LIMIT_CODE_LO];
            voltage_scale_select <= ml_q[`HSCR_VSCALE_BIT];
            power_voltage_source <= ml_q[`HSCR_PWRSRC_BIT];
            fast_bus_timing <= bf_q[`HSCR_FAST_BIT];
            remote_sensor_select <= bf_q[`HSCR_RTEMP_BIT];
            gpio_pull_low <= ~(gpio_sel_out ^ pp_q[7:0]);
        end
    end
    assign enable_active = en_q;
    assign fault_bits = flt_q;
    assign power_good_latch = pg_q;
    assign reboot_req = rbt_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_mass_block;
        @(posedge clk_sys) disable iff (!rst_n)
        cmd_valid && cmd_write && cmd_mass && !bf_q[`HSCR_MASSWR_BIT] |=>
            $stable(ml_q) && $stable(bf_q) && $stable(pp_q);
    endproperty
    a_mass_block: assert property (p_mass_block) else $error("mass write landed");
    property p_write_lands;
        @(posedge clk_sys) disable iff (!rst_n)
        cmd_valid && cmd_write && !cmd_mass && hit_bf |=> bf_q == $past(cmd_wdata);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write lost");
    property p_rd_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        cmd_valid && !cmd_write && hit_ml |=> rsp_rdata[15] == 1'b0 && rsp_rdata[7] == 1'b0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("reserved bit read set");
    property p_current_limit_code;
        @(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> current_limit_code == $past(ml_q[13:10]);
    endproperty
    a_current_limit_code: assert property (p_current_limit_code) else $error("limit code mismatch");
    property p_range;
        @(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> voltage_scale_select == $past(ml_q[1]) &&
            power_voltage_source == $past(ml_q[0]);
    endproperty
    a_range: assert property (p_range) else $error("range or source mismatch");
    property p_fast;
        @(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> fast_bus_timing == $past(bf_q[12]) &&
            remote_sensor_select == $past(bf_q[2]);
    endproperty
    a_fast: assert property (p_fast) else $error("timing or sensor mismatch");
    property p_fault_clr;
        @(posedge clk_sys) disable iff (!rst_n)
        en_d && !en_q && bf_q[7] && fault_set == 16'h0000 |=> fault_bits == 16'h0000;
    endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("faults not cleared");
    property p_pg_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        bf_q[6] && !pin_q[9] |=> !power_good_latch;
    endproperty
    a_pg_clear: assert property (p_pg_clear) else $error("good latch not cleared");
    property p_pull;
        @(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> gpio_pull_low == ~($past(gpio_sel_out) ^ $past(pp_q[7:0]));
    endproperty
    a_pull: assert property (p_pull) else $error("pin pull mismatch");
    c_write: cover property (@(posedge clk_sys) cmd_valid && cmd_write && rsp_ack_d);
    c_pg: cover property (@(posedge clk_sys) $rose(power_good_latch));
    c_reboot: cover property (@(posedge clk_sys) reboot_req);
endmodule

// [tb/hscr_host_model.sv]
`timescale 1ns/1ps
// ----
// management host: one command per call, rsp taken one edge after the strobe
// ----
module hscr_host_model (
    input wire logic clk_sys,
    output logic cmd_valid,
    output logic cmd_write,
    output logic cmd_mass,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_ack,
    input wire logic [15:0] rsp_rdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_mass = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // reserved writable fields always get their fixed pattern
    function automatic logic [15:0] fix_reserved(input logic [7:0] c, input logic [15:0] w);
        case (c)
            8'hf2: return (w & ~16'hc3fc) | 16'h4170;
            8'hf3: return (w & ~16'hef19) | 16'h0009;
            8'hf4: return w & ~16'hfd00;
            default: return w;
        endcase
    endfunction

    task automatic xfer(input logic wr, input logic ms, input logic [7:0] c,
        input logic [15:0] wd, output logic vld, output logic ack, output logic [15:0] rd);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_mass <= ms;
        cmd_code <= c;
        cmd_wdata <= fix_reserved(c, wd);
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        // released lines show garbage so stale data is never mistaken for a command
        cmd_code <= ~c;
        cmd_wdata <= ~wd;
        #1;
        vld = rsp_valid;
        ack = rsp_ack;
        rd = rsp_rdata;
    endtask
endmodule

// [tb/hscr_tb_top.sv]
`timescale 1ns/1ps
`include "hscr_map.svh"
`define TB_CHECK(nm, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
end
module hscr_tb_top;
    // ----
    // signals
    // ----
    logic clk_sys, nrst, enable_pin, feedback_good, gate_good, drain_good, fet_on;
    logic [15:0] fault_set, cmd_wdata, rsp_rdata, fault_bits, d, r;
    logic [7:0] reboot_pin, gpio_sel_out, cmd_code, gpio_pull_low;
    logic cmd_valid, cmd_write, cmd_mass, rsp_valid, rsp_ack, v, a;
    logic [3:0] current_limit_code;
    logic voltage_scale_select, power_voltage_source, fast_bus_timing, remote_sensor_select;
    logic enable_active, power_good_latch, reboot_req;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    hscr_top #(.DEBOUNCE_CYCLES(4)) u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_mass(cmd_mass), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .fault_set(fault_set), .enable_pin(enable_pin), .feedback_good(feedback_good),
        .gate_good(gate_good), .drain_good(drain_good), .fet_on(fet_on),
        .reboot_pin(reboot_pin), .gpio_sel_out(gpio_sel_out), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_ack(rsp_ack), .current_limit_code(current_limit_code),
        .voltage_scale_select(voltage_scale_select),
        .power_voltage_source(power_voltage_source),
        .fast_bus_timing(fast_bus_timing), .remote_sensor_select(remote_sensor_select),
        .enable_active(enable_active), .fault_bits(fault_bits),
        .power_good_latch(power_good_latch), .reboot_req(reboot_req),
        .gpio_pull_low(gpio_pull_low)
    );
    hscr_host_model u_host (
        .clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_mass(cmd_mass), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // run is a few hundred cycles; the ceiling only catches a hang
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    function automatic logic [15:0] exp_rd(input logic [7:0] c, input logic [15:0] w);
        logic [15:0] f;
        f = u_host.fix_reserved(c, w);
        case (c)
            8'hf2: return f & `HSCR_RD_MASK_MONITOR_LIMIT;
            8'hf3: return f & `HSCR_RD_MASK_BUS_FAULT;
            default: return f & `HSCR_RD_MASK_PIN_POLARITY;
        endcase
    endfunction

    // per pin: inverted polarity pulls low on a high bit, plain polarity on a low bit
    function automatic logic [7:0] exp_pull(input logic [7:0] s, input logic [7:0] p);
        for (int k = 0; k < 8; k++) begin
            exp_pull[k] = p[k] ? s[k] : !s[k];
        end
    endfunction

    task automatic settle(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] w, input logic ms, input logic ea);
        u_host.xfer(1'b1, ms, c, w, v, a, r);
        `TB_CHECK("wr valid", 1'b1, v)
        `TB_CHECK("wr ack", ea, a)
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        u_host.xfer(1'b0, 1'b0, c, 16'h0000, v, a, r);
        `TB_CHECK("rd data", e, r)
    endtask

    task automatic wait_en(input logic lvl);
        n = 0;
        while (enable_active !== lvl && n < 40) begin
            settle(1);
            n++;
        end
        `TB_CHECK("enable active", lvl, enable_active)
    endtask

    task automatic cnt_reboot(input int e);
        n = 0;
        repeat (10) begin
            settle(1);
            n += int'(reboot_req === 1'b1);
        end
        `TB_CHECK("reboot pulses", e, n)
    endtask

    // ----
    // tests
    // ----
    initial begin
        nrst = 1'b0;
        enable_pin = 1'b0;
        feedback_good = 1'b0;
        gate_good = 1'b0;
        drain_good = 1'b0;
        fet_on = 1'b0;
        fault_set = 16'h0000;
        reboot_pin = 8'h00;
        gpio_sel_out = 8'h00;
        void'($urandom(32'ha5b1));
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        settle(5);
        `TB_CHECK("limit code", 4'h5, current_limit_code)
        `TB_CHECK("range", 1'b1, voltage_scale_select)
        `TB_CHECK("power src", 1'b0, power_voltage_source)
        `TB_CHECK("fast timing", 1'b0, fast_bus_timing)
        `TB_CHECK("remote sensor", 1'b1, remote_sensor_select)
        `TB_CHECK("pull low", 8'h64, gpio_pull_low)
        rd(8'hf2, `HSCR_RST_MONITOR_LIMIT & `HSCR_RD_MASK_MONITOR_LIMIT);
        rd(8'hf3, `HSCR_RST_BUS_FAULT & `HSCR_RD_MASK_BUS_FAULT);
        rd(8'hf4, `HSCR_RST_PIN_POLARITY & `HSCR_RD_MASK_PIN_POLARITY);
        u_host.xfer(1'b0, 1'b0, 8'hf5, 16'h0000, v, a, r);
        `TB_CHECK("unknown ack", 1'b0, a)
        wr(8'hf1, 16'hffff, 1'b0, 1'b0);
        $display("test defaults done");
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
            wr(8'hf2, d, 1'b0, 1'b1);
            rd(8'hf2, exp_rd(8'hf2, d));
            `TB_CHECK("limit code", d[13:10], current_limit_code)
            `TB_CHECK("range", d[1], voltage_scale_select)
            `TB_CHECK("power src", d[0], power_voltage_source)
        end
        $display("test monitor word done");
        for (int i = 0; i < 2; i++) begin
            wr(8'hf3, 16'h1000 | 16'(i * 4), 1'b0, 1'b1);
            rd(8'hf3, exp_rd(8'hf3, 16'h1000 | 16'(i * 4)));
            `TB_CHECK("fast timing", 1'b1, fast_bus_timing)
            `TB_CHECK("remote sensor", i[0], remote_sensor_select)
        end
        d = 16'($urandom);
        wr(8'hf4, d, 1'b1, 1'b0);
        rd(8'hf4, `HSCR_RST_PIN_POLARITY & `HSCR_RD_MASK_PIN_POLARITY);
        wr(8'hf3, 16'h0062, 1'b0, 1'b1);
        wr(8'hf4, d, 1'b1, 1'b1);
        rd(8'hf4, exp_rd(8'hf4, d));
        `TB_CHECK("fast timing", 1'b0, fast_bus_timing)
        repeat (4) begin
            d = 16'($urandom);
            wr(8'hf4, d, 1'b0, 1'b1);
            @(posedge clk_sys);
            gpio_sel_out <= 8'($urandom);
            settle(3);
            `TB_CHECK("pull low", exp_pull(gpio_sel_out, d[7:0]), gpio_pull_low)
        end
        $display("test bus and pins done");
        d = 16'($urandom) | 16'h0001;
        @(posedge clk_sys);
        fault_set <= d;
        @(posedge clk_sys);
        fault_set <= 16'h0000;
        enable_pin <= 1'b1;
        wait_en(1'b1);
        settle(3);
        `TB_CHECK("faults kept", d, fault_bits)
        @(posedge clk_sys);
        enable_pin <= 1'b0;
        wait_en(1'b0);
        wr(8'hf3, 16'h00e2, 1'b0, 1'b1);
        @(posedge clk_sys);
        enable_pin <= 1'b1;
        wait_en(1'b1);
        settle(3);
        `TB_CHECK("faults cleared", 16'h0000, fault_bits)
        $display("test faults done");
        @(posedge clk_sys);
        gate_good <= 1'b1;
        drain_good <= 1'b1;
        feedback_good <= 1'b1;
        fet_on <= 1'b1;
        settle(8);
        `TB_CHECK("good latch", 1'b1, power_good_latch)
        @(posedge clk_sys);
        fet_on <= 1'b0;
        settle(8);
        `TB_CHECK("good latch", 1'b1, power_good_latch)
        @(posedge clk_sys);
        feedback_good <= 1'b0;
        settle(8);
        `TB_CHECK("good latch", 1'b0, power_good_latch)
        @(posedge clk_sys);
        feedback_good <= 1'b1;
        fet_on <= 1'b1;
        wr(8'hf3, 16'h00a2, 1'b0, 1'b1);
        @(posedge clk_sys);
        feedback_good <= 1'b0;
        settle(8);
        `TB_CHECK("good latch", 1'b1, power_good_latch)
        @(posedge clk_sys);
        fet_on <= 1'b0;
        settle(8);
        `TB_CHECK("good latch", 1'b0, power_good_latch)
        $display("test power good done");
        wr(8'hf4, 16'h0000, 1'b0, 1'b1);
        @(posedge clk_sys);
        reboot_pin <= 8'h01;
        cnt_reboot(1);
        @(posedge clk_sys);
        reboot_pin <= 8'h00;
        cnt_reboot(0);
        wr(8'hf4, 16'h0200, 1'b0, 1'b1);
        @(posedge clk_sys);
        reboot_pin <= 8'h10;
        cnt_reboot(0);
        @(posedge clk_sys);
        reboot_pin <= 8'h00;
        cnt_reboot(1);
        $display("test reboot done");
        // debounce off: enable follows the synchroniser; on: it lags by the timer
        wr(8'hf3, 16'h00e0, 1'b0, 1'b1);
        @(posedge clk_sys);
        enable_pin <= 1'b0;
        settle(6);
        `TB_CHECK("enable direct", 1'b0, enable_active)
        wr(8'hf3, 16'h00e2, 1'b0, 1'b1);
        @(posedge clk_sys);
        enable_pin <= 1'b1;
        settle(6);
        `TB_CHECK("enable held", 1'b0, enable_active)
        wait_en(1'b1);
        $display("test debounce done");
        // mid-run reset must bring every word back to its default
        @(posedge clk_sys);
        nrst <= 1'b0;
        settle(3);
        @(posedge clk_sys);
        nrst <= 1'b1;
        settle(5);
        `TB_CHECK("limit code", 4'h5, current_limit_code)
        rd(8'hf2, `HSCR_RST_MONITOR_LIMIT & `HSCR_RD_MASK_MONITOR_LIMIT);
        rd(8'hf3, `HSCR_RST_BUS_FAULT & `HSCR_RD_MASK_BUS_FAULT);
        rd(8'hf4, `HSCR_RST_PIN_POLARITY & `HSCR_RD_MASK_PIN_POLARITY);
        $display("test reset done");
        print_verdict();
    end
endmodule
